// ==== verilog/mcu_bit_logic_call_ops.sv ====
// Functional notes
// RL1 - AND accumulator with 8-bit immediate, result to accumulator, zero flag updated.
// RL2 - Set selected bit of addressed register, other bits kept, flags untouched.
// RL3 - Test selected register bit; skip next instruction when it is zero.
// RL4 - Skip discards fetched instruction, runs a no-op; a skipping test takes two cycles, a non-skipping test one.
// RL5 - Test takes 7-bit register address and 3-bit bit selector.
// RL6 - Call pushes program counter plus one onto return stack first.
// RL7 - Call target: high byte bits 2..0 to PC 10..8, accumulator to PC 7..0.
// RL8 - Each push increments stack pointer; call completes in two cycles.
// RL9 - Table-pointer high byte holds upper part of program memory target.
`timescale 1ns/100ps
`include "bitops_defs.svh"

module mcu_bit_logic_call_ops
#(
  parameter int STACK_DEPTH = 8,
  parameter int SP_W        = 3
)
(
  input  wire logic                     mclk_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     issue_in,
  input  wire bitops_pkg::op_e          op_in,
  input  wire logic [7:0]               immediate_in,
  input  wire logic [`REG_ADDR_W-1:0]   reg_addr_in,
  input  wire logic [`BIT_SEL_W-1:0]    bit_sel_in,
  input  wire logic [7:0]               reg_rdata_in,
  input  wire logic [7:0]               table_pointer_high_byte_in,
  input  wire logic [`PC_W-1:0]         pc_in,
  input  wire logic                     acc_load_in,
  input  wire logic [7:0]               acc_load_data_in,
  output logic [7:0]                    accumulator_out,
  output logic                          zero_flag_out,
  output logic                          reg_we_out,
  output logic [`REG_ADDR_W-1:0]        reg_waddr_out,
  output logic [7:0]                    reg_wdata_out,
  output logic                          discard_next_out,
  output logic                          busy_out,
  output logic                          pc_load_out,
  output logic [`PC_W-1:0]              pc_target_out,
  output logic [SP_W-1:0]               stack_ptr_out,
  output logic [`PC_W-1:0]              stack_top_out
);
  import bitops_pkg::*;

  logic [`PC_W-1:0] stack_q [STACK_DEPTH];
  logic [1:0]       busy_cnt_q;
  logic             call_pend_q;
  logic [`PC_W-1:0] call_target_q;

  wire do_and  = issue_in && !busy_out && op_in == op_and_immediate_into_acc;
  wire do_set  = issue_in && !busy_out && op_in == op_set_register_bit;
  wire do_test = issue_in && !busy_out && op_in == op_test_bit_skip_when_clear;
  wire do_call = issue_in && !busy_out && op_in == op_call_via_accumulator;

  function automatic logic [7:0] bit_mask(input logic [`BIT_SEL_W-1:0] sel);
    bit_mask = 8'h01 << sel;
  endfunction

  function automatic logic bit_is_clear(input logic [7:0]            data,
                                        input logic [`BIT_SEL_W-1:0] sel);
    bit_is_clear = (data & bit_mask(sel)) == 8'h00;
  endfunction

  wire skip_now = do_test && bit_is_clear(reg_rdata_in, bit_sel_in); // RL3 RL5

  wire [7:0] and_result = accumulator_out & immediate_in;

  always_ff @(posedge mclk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      accumulator_out <= `ACC_RESET;
      zero_flag_out   <= 1'b0;
    end
    else if (do_and)
    begin
      accumulator_out <= and_result; // RL1
      zero_flag_out   <= (and_result == 8'h00); // RL1
    end
    // Other instructions write the accumulator here; an AND in the same cycle wins
    else if (acc_load_in)
      accumulator_out <= acc_load_data_in;

  always_ff @(posedge mclk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      reg_we_out    <= 1'b0;
      reg_waddr_out <= '0;
      reg_wdata_out <= 8'h00;
    end
    else
    begin
      reg_we_out <= do_set;
      if (do_set)
      begin
        reg_waddr_out <= reg_addr_in;
        reg_wdata_out <= reg_rdata_in | bit_mask(bit_sel_in); // RL2
      end
    end

  // Skip: reg_rdata_in is the addressed register read for the current op
  always_ff @(posedge mclk_in or negedge rst_n_in)
    if (!rst_n_in)
      discard_next_out <= 1'b0;
    else
      discard_next_out <= skip_now; // RL3 RL5

  always_ff @(posedge mclk_in or negedge rst_n_in)
    if (!rst_n_in)
      busy_cnt_q <= 2'h0;
    else if (do_call)
      busy_cnt_q <= `CALL_CYCLES - 2'h1; // RL8
    else if (skip_now)
      busy_cnt_q <= 2'h1; // RL4
    else if (busy_cnt_q != 2'h0)
      busy_cnt_q <= busy_cnt_q - 2'h1;

  always_ff @(posedge mclk_in or negedge rst_n_in)
    if (!rst_n_in)
      busy_out <= 1'b0;
    else
      busy_out <= do_call || skip_now || busy_cnt_q > 2'h1; // RL4 RL8

  always_ff @(posedge mclk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      stack_ptr_out <= '0;
      stack_top_out <= `PC_RESET;
    end
    else if (do_call)
    begin
      stack_top_out          <= pc_in + `PC_W'(1); // RL6
      stack_ptr_out          <= stack_ptr_out + SP_W'(1); // RL8
    end

  // Entries carry no reset; only pushed entries are ever read back
  always_ff @(posedge mclk_in)
    if (do_call)
      stack_q[stack_ptr_out] <= pc_in + `PC_W'(1); // RL6

  always_ff @(posedge mclk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      call_pend_q   <= 1'b0;
      call_target_q <= `PC_RESET;
    end
    else
    begin
      call_pend_q <= do_call;
      if (do_call)
        call_target_q <= {table_pointer_high_byte_in[`TBH_PC_BITS-1:0],
                          accumulator_out}; // RL7 RL9
    end

  // PC changes only after the push cycle
  always_ff @(posedge mclk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      pc_load_out   <= 1'b0;
      pc_target_out <= `PC_RESET;
    end
    else
    begin
      pc_load_out <= call_pend_q; // RL6 RL8
      if (call_pend_q)
        pc_target_out <= call_target_q; // RL7
    end

  a_and_result: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL1
    do_and |=> accumulator_out == $past(and_result) && zero_flag_out == ($past(and_result) == 8'h00))
    else $error("and result wrong");
  a_set_bit: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL2
    do_set |=> reg_we_out && reg_wdata_out[$past(bit_sel_in)] && zero_flag_out == $past(zero_flag_out))
    else $error("set bit wrong");

  sequence skip_seq;
    (discard_next_out && busy_out) ##1 (!discard_next_out && !busy_out);
  endsequence
  a_skip_taken: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL3 RL4
    do_test && !reg_rdata_in[bit_sel_in] |=> skip_seq)
    else $error("skip missing");
  a_no_skip: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL3
    do_test && reg_rdata_in[bit_sel_in] |=> !discard_next_out && !busy_out)
    else $error("spurious skip");
  a_skip_length: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL4
    discard_next_out |=> !busy_out && !discard_next_out)
    else $error("skip too long");
  a_push_value: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL6
    do_call |=> stack_top_out == $past(pc_in) + `PC_W'(1))
    else $error("push value wrong");
  sequence call_seq;
    do_call ##1 !pc_load_out ##1 pc_load_out;
  endsequence
  a_call_order: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL8
    do_call |-> call_seq)
    else $error("call timing wrong");
  a_call_target: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL7
    do_call |-> ##2 pc_target_out == {$past(table_pointer_high_byte_in[2:0], 2),
                                      $past(accumulator_out, 2)})
    else $error("call target wrong");
  a_sp_inc: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL8
    do_call |=> stack_ptr_out == $past(stack_ptr_out) + SP_W'(1))
    else $error("stack pointer wrong");

  a_set_others: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL2
    do_set |=> reg_waddr_out == $past(reg_addr_in)
               && (reg_wdata_out & ~bit_mask($past(bit_sel_in)))
                  == ($past(reg_rdata_in) & ~bit_mask($past(bit_sel_in))))
    else $error("set bit disturbed other bits");
  a_zero_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL2
    !do_and |=> $stable(zero_flag_out))
    else $error("zero flag changed outside and");

  a_stack_entry: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL6
    do_call |=> stack_q[$past(stack_ptr_out)] == $past(pc_in) + `PC_W'(1))
    else $error("stack entry wrong");
  a_busy_refuse: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL4 RL8
    busy_out |=> !reg_we_out && !discard_next_out && $stable(stack_ptr_out))
    else $error("issue taken while busy");
  a_pc_load_pulse: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL8
    pc_load_out |=> !pc_load_out)
    else $error("pc load longer than one cycle");
endmodule

// ==== verilog/bitops_defs.svh ====
`ifndef BITOPS_DEFS_SVH
`define BITOPS_DEFS_SVH

`define PC_W          11
`define REG_ADDR_W    7
`define BIT_SEL_W     3
`define PC_RESET      11'h000
`define ACC_RESET     8'h00
`define SP_RESET      3'h0
`define CALL_CYCLES   2'h2
`define TBH_PC_BITS   3

`endif

// ==== verilog/bitops_pkg.sv ====
package bitops_pkg;
  typedef enum logic [2:0]
  {
    op_none,
    op_and_immediate_into_acc,
    op_set_register_bit,
    op_test_bit_skip_when_clear,
    op_call_via_accumulator
  } op_e;
endpackage

// ==== bench/mcu_bit_logic_call_ops_bench.sv ====
`timescale 1ns/100ps
module mcu_bit_logic_call_ops_bench;
  import bitops_pkg::*;
  typedef struct {op_e op; logic [6:0] a; logic [2:0] b; logic [7:0] r;
                  logic [7:0] w; logic d; logic [7:0] k; logic z;} row_s;
  logic        mclk_in, rst_n_in, issue_in, zf_o, we, disc, busy, pl, acc_ld;
  op_e         op_in;
  logic [6:0]  addr, wa;
  logic [2:0]  bsel, sp;
  logic [7:0]  rd, tbh, acc, wd, acc_wd;
  logic [10:0] pc, pt, st;
  int          err_count, samples_checked;
  // Columns: op, address, bit, read data, write data, skip, accumulator, zero
  row_s        rows [8] = '{
    '{op_set_register_bit, 7'h7f, 3'h2, 8'h5a, 8'h5e, 1'b0, 8'h5a, 1'b0},
    '{op_set_register_bit, 7'h00, 3'h7, 8'h00, 8'h80, 1'b0, 8'h5a, 1'b0},
    '{op_test_bit_skip_when_clear, 7'h7f, 3'h2, 8'h5a, 8'h00, 1'b1, 8'h5a, 1'b0},
    '{op_test_bit_skip_when_clear, 7'h01, 3'h3, 8'h5a, 8'h00, 1'b0, 8'h5a, 1'b0},
    '{op_and_immediate_into_acc, 7'h00, 3'h0, 8'haf, 8'h00, 1'b0, 8'h0a, 1'b0},
    '{op_test_bit_skip_when_clear, 7'h40, 3'h7, 8'h7f, 8'h00, 1'b1, 8'h0a, 1'b0},
    '{op_and_immediate_into_acc, 7'h00, 3'h0, 8'h50, 8'h00, 1'b0, 8'h00, 1'b1},
    '{op_set_register_bit, 7'h05, 3'h0, 8'hfe, 8'hff, 1'b0, 8'h00, 1'b1}};

  mcu_bit_logic_call_ops mcu_bit_logic_call_ops_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .issue_in(issue_in), .op_in(op_in), .immediate_in(rd), .reg_addr_in(addr),
    .bit_sel_in(bsel), .reg_rdata_in(rd), .table_pointer_high_byte_in(tbh), .pc_in(pc),
    .acc_load_in(acc_ld), .acc_load_data_in(acc_wd),
    .accumulator_out(acc), .zero_flag_out(zf_o), .reg_we_out(we), .reg_waddr_out(wa),
    .reg_wdata_out(wd), .discard_next_out(disc), .busy_out(busy), .pc_load_out(pl),
    .pc_target_out(pt), .stack_ptr_out(sp), .stack_top_out(st));

  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(logic [10:0] s, logic [10:0] e);
    samples_checked++;
    if (s !== e)
    begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask

  // Raises one issue for a rising edge and returns at the next falling edge, still raised
  task go(op_e o, logic [6:0] a, logic [2:0] b, logic [7:0] r);
    issue_in = 1'b1; op_in = o; addr = a; bsel = b; rd = r;
    @(negedge mclk_in);
  endtask

  task chk_reset;
    chk({acc, zf_o, we, disc}, 11'h000);
    chk({busy, pl, sp}, 11'h000);
    chk(st, 11'h000);
    chk(pt, 11'h000);
    chk(wa, 11'h000);
    chk(wd, 11'h000);
    $display("reset test done");
  endtask

  // Loads the accumulator a cycle ahead, then calls; a set issued while busy must be dropped
  task call(logic [10:0] p, logic [7:0] t, logic [7:0] k, logic [2:0] s);
    acc_ld = 1'b1; acc_wd = k; pc = p; tbh = t;
    @(negedge mclk_in);
    acc_ld = 1'b0;
    go(op_call_via_accumulator, 7'h00, 3'h0, 8'h00);
    chk(st, p + 11'h001);
    chk(sp, s);
    chk(busy, 1'b1);
    chk(pl, 1'b0);
    go(op_set_register_bit, 7'h11, 3'h1, 8'h00);
    issue_in = 1'b0;
    chk(we, 1'b0);
    chk(busy, 1'b0);
    chk(pl, 1'b1);
    chk(pt, {t[2:0], k});
    @(negedge mclk_in);
    chk(pl, 1'b0);
    chk(pt, {t[2:0], k});
    $display("call test done");
  endtask

  initial
  begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  initial
  begin
    #(400 * 8);
    err_count++;
    close_out;
  end

  initial
  begin
    rst_n_in = 1'b0; issue_in = 1'b0; op_in = op_none; addr = 7'h00; bsel = 3'h0;
    rd = 8'h00; tbh = 8'h00; pc = 11'h000; acc_ld = 1'b0; acc_wd = 8'h00;
    repeat (6) @(negedge mclk_in);
    rst_n_in = 1'b1;
    chk_reset;
    acc_ld = 1'b1; acc_wd = 8'h5a;
    @(negedge mclk_in);
    acc_ld = 1'b0;
    chk(acc, 11'h05a);
    chk(zf_o, 1'b0);
    foreach (rows[i])
    begin
      go(rows[i].op, rows[i].a, rows[i].b, rows[i].r);
      issue_in = 1'b0;
      chk(we, rows[i].op == op_set_register_bit);
      if (rows[i].op == op_set_register_bit)
      begin
        chk(wa, rows[i].a);
        chk(wd, rows[i].w);
      end
      chk(disc, rows[i].d);
      chk(busy, rows[i].d);
      chk(acc, rows[i].k);
      chk(zf_o, rows[i].z);
      @(negedge mclk_in);
      chk({busy, disc}, 11'h000);
      $display("row %0d done", i);
    end
    call(11'h0a0, 8'h02, 8'h34, 3'h1);
    call(11'h7ff, 8'hff, 8'hc3, 3'h2);
    rst_n_in = 1'b0;
    @(negedge mclk_in);
    chk_reset;
    rst_n_in = 1'b1;
    go(op_and_immediate_into_acc, 7'h00, 3'h0, 8'hff);
    issue_in = 1'b0;
    chk(acc, 11'h000);
    chk(zf_o, 1'b1);
    $display("restart test done");
    close_out;
  end
endmodule
